// *** rtl/pcis_pkg.sv ***
// shared constants, states and parity for both bus ends
`default_nettype none
package pcis_pkg;
  localparam int DATA_W = 32;
  localparam int LANE_W = 8;
  localparam int NUM_LANES = 4;
  localparam int LEN_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 36;
  localparam int MEM_WIN_BITS = 12;
  localparam logic [31:0] MEM_BASE_DEF = 32'h1000_0000;
  localparam logic [31:0] BUS_PULL = 32'hFFFF_FFFF;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] BE_ALL_N = 4'h0;
  localparam logic [3:0] MABORT_CLK = 4'h5;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam logic [7:0] LEN_TWO = 8'h02;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_DATA = 2'b01,
    TS_HOLD = 2'b10,
    TS_TURN = 2'b11
  } pcis_tst_t;

  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_REQ = 3'b001,
    MS_ADDR = 3'b010,
    MS_DATA = 3'b011,
    MS_TURN = 3'b100
  } pcis_mst_t;

  // even parity over the lines a driver puts on the bus
  function automatic logic pcis_par(input logic [31:0] a, input logic [3:0] c);
    return ^{a, c};
  endfunction
endpackage
`default_nettype wire

// *** rtl/pcis_if.sv ***
// shared bus wires between device end and host end
`timescale 1ns/1ps
`default_nettype none
interface pcis_if import pcis_pkg::*; ();
  logic [31:0] ad, d_ad, h_ad;
  logic [3:0] cbe, d_cbe, h_cbe;
  logic par, frame_n, irdy_n, trdy_n, stop_n, devsel_n, idsel, req_n, gnt_n;
  logic d_ad_oe_n, d_cbe_oe_n, d_par, d_par_oe_n, d_frame_n, d_irdy_n, d_mctl_oe_n;
  logic d_trdy_n, d_stop_n, d_devsel_n, d_tctl_oe_n, d_req_n;
  logic h_ad_oe_n, h_cbe_oe_n, h_par, h_par_oe_n, h_frame_n, h_irdy_n, h_mctl_oe_n;
  logic h_trdy_n, h_stop_n, h_devsel_n, h_tctl_oe_n, h_idsel, h_gnt_n;

  // ****************************************
  // wire resolution, undriven lines pull high
  // ****************************************
  // device end wins where both ends drive a line
  assign ad = !d_ad_oe_n ? d_ad : (!h_ad_oe_n ? h_ad : BUS_PULL);
  assign cbe = !d_cbe_oe_n ? d_cbe : (!h_cbe_oe_n ? h_cbe : BUS_PULL[3:0]);
  assign par = !d_par_oe_n ? d_par : (!h_par_oe_n ? h_par : 1'h1);
  assign frame_n = !d_mctl_oe_n ? d_frame_n : (!h_mctl_oe_n ? h_frame_n : 1'h1);
  assign irdy_n = !d_mctl_oe_n ? d_irdy_n : (!h_mctl_oe_n ? h_irdy_n : 1'h1);
  assign trdy_n = !d_tctl_oe_n ? d_trdy_n : (!h_tctl_oe_n ? h_trdy_n : 1'h1);
  assign stop_n = !d_tctl_oe_n ? d_stop_n : (!h_tctl_oe_n ? h_stop_n : 1'h1);
  assign devsel_n = !d_tctl_oe_n ? d_devsel_n : (!h_tctl_oe_n ? h_devsel_n : 1'h1);
  assign idsel = h_idsel;
  assign req_n = d_req_n;
  assign gnt_n = h_gnt_n;

  modport dev (
    input ad, cbe, par, frame_n, irdy_n, trdy_n, stop_n, devsel_n, idsel, gnt_n,
    output d_ad, d_ad_oe_n, d_cbe, d_cbe_oe_n, d_par, d_par_oe_n, d_frame_n, d_irdy_n,
    output d_mctl_oe_n, d_trdy_n, d_stop_n, d_devsel_n, d_tctl_oe_n, d_req_n
  );
  modport host (
    input ad, cbe, par, frame_n, irdy_n, trdy_n, stop_n, devsel_n, req_n,
    output h_ad, h_ad_oe_n, h_cbe, h_cbe_oe_n, h_par, h_par_oe_n, h_frame_n, h_irdy_n,
    output h_mctl_oe_n, h_trdy_n, h_stop_n, h_devsel_n, h_tctl_oe_n, h_idsel, h_gnt_n
  );
endinterface
`default_nettype wire

// *** rtl/pcis_dev.sv ***
// device end: target into a write fifo, single-word write master
`timescale 1ns/1ps
`default_nettype none
module pcis_fifo import pcis_pkg::*; #(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } pcis_fst_t;
  pcis_fst_t s_reg, s_next;
  logic push, pop;

  always_comb begin
    s_next = s_reg;
    push = in_valid_i && (s_reg.cnt != (AW+1)'(DEPTH));
    pop = out_ready_i && (s_reg.cnt != '0);
    if (push) begin
      s_next.mem[s_reg.wp] = in_data_i;
      s_next.wp = s_reg.wp + 1'h1;
    end
    if (pop) begin
      s_next.rp = s_reg.rp + 1'h1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready_o = s_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = s_reg.cnt != '0;
  assign out_data_o = s_reg.mem[s_reg.rp];
  assign level_o = s_reg.cnt;
endmodule

module pcis_dev import pcis_pkg::*; #(
  parameter logic [31:0] MEM_BASE = MEM_BASE_DEF,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  pcis_if.dev bus,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_be_n_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  input wire logic mst_start_i,
  input wire logic [31:0] mst_addr_i,
  input wire logic [31:0] mst_data_i,
  output logic mst_busy_o,
  output logic mst_done_o,
  output logic mst_abort_o,
  output logic [31:0] cfg_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    pcis_tst_t tst;
    pcis_mst_t mst;
    logic frame_q, wr, cfg, busy, done, abort, req_n;
    logic [31:0] ad, maddr, mdata, cfg_reg;
    logic [3:0] cbe, tmo;
    logic par, ad_oe_n, cbe_oe_n, par_oe_n, mctl_oe_n, tctl_oe_n;
    logic frame_n, irdy_n, trdy_n, stop_n, devsel_n;
  } pcis_dst_t;
  localparam pcis_dst_t D_RST = '{tst: TS_IDLE, mst: MS_IDLE, frame_q: 1'h1, req_n: 1'h1,
    ad_oe_n: 1'h1, cbe_oe_n: 1'h1, par_oe_n: 1'h1, mctl_oe_n: 1'h1, tctl_oe_n: 1'h1,
    frame_n: 1'h1, irdy_n: 1'h1, trdy_n: 1'h1, stop_n: 1'h1, devsel_n: 1'h1, default: '0};

  pcis_dst_t s_reg, s_next;
  logic push, in_ready, hit_cfg, hit_mem, xfer, fin;
  logic [AW:0] level;
  logic [FIFO_WIDTH-1:0] fifo_dout;

  // ****************************************
  // bus state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'h0;
    s_next.abort = 1'h0;
    s_next.frame_q = bus.frame_n;
    push = 1'h0;
    fin = 1'h0;
    xfer = !bus.irdy_n && !s_reg.trdy_n;
    hit_cfg = (bus.cbe == CMD_CFG_RD || bus.cbe == CMD_CFG_WR) && bus.idsel;
    hit_mem = (bus.cbe == CMD_MEM_RD || bus.cbe == CMD_MEM_WR) &&
              (bus.ad[31:MEM_WIN_BITS] == MEM_BASE[31:MEM_WIN_BITS]);
    case (s_reg.mst)
      MS_IDLE: begin
        if (mst_start_i) begin
          s_next.maddr = mst_addr_i;
          s_next.mdata = mst_data_i;
          s_next.busy = 1'h1;
          s_next.req_n = 1'h0;
          s_next.mst = MS_REQ;
        end
      end
      MS_REQ: begin
        if (!bus.gnt_n && bus.frame_n && bus.irdy_n && s_reg.tst == TS_IDLE) begin
          s_next.req_n = 1'h1;
          s_next.frame_n = 1'h0;
          s_next.irdy_n = 1'h1;
          s_next.mctl_oe_n = 1'h0;
          s_next.ad = s_reg.maddr;
          s_next.cbe = CMD_MEM_WR;
          s_next.ad_oe_n = 1'h0;
          s_next.cbe_oe_n = 1'h0;
          s_next.par_oe_n = 1'h0;
          s_next.mst = MS_ADDR;
        end
      end
      MS_ADDR: begin
        s_next.frame_n = 1'h1;
        s_next.irdy_n = 1'h0;
        s_next.ad = s_reg.mdata;
        s_next.cbe = BE_ALL_N;
        s_next.tmo = '0;
        s_next.mst = MS_DATA;
      end
      MS_DATA: begin
        if (bus.devsel_n && s_reg.tmo != MABORT_CLK) begin
          s_next.tmo = s_reg.tmo + 4'h1;
        end
        fin = !bus.trdy_n || !bus.stop_n || (s_reg.tmo == MABORT_CLK);
        if (fin) begin
          s_next.done = !bus.trdy_n;
          s_next.abort = bus.trdy_n;
          s_next.irdy_n = 1'h1;
          s_next.ad_oe_n = 1'h1;
          s_next.cbe_oe_n = 1'h1;
          s_next.par_oe_n = 1'h1;
          s_next.mst = MS_TURN;
        end
      end
      MS_TURN: begin
        s_next.mctl_oe_n = 1'h1;
        s_next.busy = 1'h0;
        s_next.mst = MS_IDLE;
      end
      default: begin
        s_next.mst = MS_IDLE;
      end
    endcase

    case (s_reg.tst)
      TS_IDLE: begin
        if (!bus.frame_n && s_reg.frame_q && s_reg.mctl_oe_n && (hit_cfg || hit_mem)) begin
          s_next.wr = bus.cbe[0];
          s_next.cfg = hit_cfg;
          s_next.devsel_n = 1'h0;
          s_next.tctl_oe_n = 1'h0;
          s_next.tst = TS_DATA;
          if (bus.cbe[0]) begin
            s_next.trdy_n = !(hit_cfg || in_ready);
          end else begin
            s_next.trdy_n = 1'h0;
            s_next.stop_n = 1'h0;
            s_next.ad = s_reg.cfg_reg;
            s_next.ad_oe_n = 1'h0;
            s_next.par_oe_n = 1'h0;
          end
        end
      end
      TS_DATA: begin
        if (xfer) begin
          if (s_reg.wr && s_reg.cfg) begin
            for (int i = 0; i < NUM_LANES; i++) begin
              if (!bus.cbe[i]) begin
                s_next.cfg_reg[i*LANE_W +: LANE_W] = bus.ad[i*LANE_W +: LANE_W];
              end
            end
          end else if (s_reg.wr) begin
            push = 1'h1;
          end
        end
        if ((xfer || bus.irdy_n) && bus.frame_n) begin
          s_next.trdy_n = 1'h1;
          s_next.stop_n = 1'h1;
          s_next.devsel_n = 1'h1;
          s_next.ad_oe_n = 1'h1;
          s_next.par_oe_n = 1'h1;
          s_next.tst = TS_TURN;
        end else if (xfer && !s_reg.wr) begin
          s_next.trdy_n = 1'h1;
          s_next.ad_oe_n = 1'h1;
          s_next.par_oe_n = 1'h1;
          s_next.tst = TS_HOLD;
        end else if (s_reg.wr && !s_reg.cfg) begin
          s_next.trdy_n = !((level + (AW+1)'(push)) < (AW+1)'(DEPTH));
        end
      end
      TS_HOLD: begin
        if (bus.frame_n) begin
          s_next.stop_n = 1'h1;
          s_next.devsel_n = 1'h1;
          s_next.tst = TS_TURN;
        end
      end
      TS_TURN: begin
        s_next.tctl_oe_n = 1'h1;
        s_next.tst = TS_IDLE;
      end
      default: begin
        s_next.tst = TS_IDLE;
      end
    endcase
    // covers address or data with lanes
    s_next.par = pcis_par(s_next.ad, s_next.cbe_oe_n ? bus.cbe : s_next.cbe);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_reg <= D_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // write data buffer
  // ****************************************
  // burst words queue here
  // lane order kept as on bus
  pcis_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push),
    .in_ready_o(in_ready),
    .in_data_i({bus.cbe, bus.ad}),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(fifo_dout),
    .level_o(level)
  );

  assign wr_data_o = fifo_dout[DATA_W-1:0];
  assign wr_be_n_o = fifo_dout[FIFO_WIDTH-1:DATA_W];
  assign mst_busy_o = s_reg.busy;
  assign mst_done_o = s_reg.done;
  assign mst_abort_o = s_reg.abort;
  assign cfg_o = s_reg.cfg_reg;
  assign bus.d_ad = s_reg.ad;
  assign bus.d_ad_oe_n = s_reg.ad_oe_n;
  assign bus.d_cbe = s_reg.cbe;
  assign bus.d_cbe_oe_n = s_reg.cbe_oe_n;
  assign bus.d_par = s_reg.par;
  assign bus.d_par_oe_n = s_reg.par_oe_n;
  assign bus.d_frame_n = s_reg.frame_n;
  assign bus.d_irdy_n = s_reg.irdy_n;
  assign bus.d_mctl_oe_n = s_reg.mctl_oe_n;
  assign bus.d_trdy_n = s_reg.trdy_n;
  assign bus.d_stop_n = s_reg.stop_n;
  assign bus.d_devsel_n = s_reg.devsel_n;
  assign bus.d_tctl_oe_n = s_reg.tctl_oe_n;
  assign bus.d_req_n = s_reg.req_n;
endmodule
`default_nettype wire

// *** rtl/pcis_host.sv ***
// host end: arbiter, burst master and write-only target
`timescale 1ns/1ps
`default_nettype none
module pcis_host import pcis_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  pcis_if.host bus,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [3:0] cmd_i,
  input wire logic [31:0] addr_i,
  input wire logic [LEN_W-1:0] len_i,
  input wire logic cfg_sel_i,
  input wire logic [31:0] wdata_i,
  input wire logic wvalid_i,
  output logic wtake_o,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  output logic done_o,
  output logic abort_o,
  output logic [31:0] tgt_data_o,
  output logic [3:0] tgt_be_n_o,
  output logic tgt_valid_o
);
  typedef struct packed {
    pcis_tst_t tst;
    pcis_mst_t mst;
    logic frame_q, wr, wtake, rvalid, tvalid, done, abort, cmd_ready, gnt_n, idsel;
    logic [31:0] ad, rdata, tdata;
    logic [3:0] cbe, tbe_n, tmo;
    logic [LEN_W-1:0] cnt;
    logic par, ad_oe_n, cbe_oe_n, par_oe_n, mctl_oe_n, tctl_oe_n;
    logic frame_n, irdy_n, trdy_n, stop_n, devsel_n;
  } pcis_hst_t;
  localparam pcis_hst_t H_RST = '{tst: TS_IDLE, mst: MS_IDLE, frame_q: 1'h1, gnt_n: 1'h1,
    ad_oe_n: 1'h1, cbe_oe_n: 1'h1, par_oe_n: 1'h1, mctl_oe_n: 1'h1, tctl_oe_n: 1'h1,
    frame_n: 1'h1, irdy_n: 1'h1, trdy_n: 1'h1, stop_n: 1'h1, devsel_n: 1'h1, default: '0};

  pcis_hst_t s_reg, s_next;
  logic xfer, last;

  always_comb begin
    s_next = s_reg;
    s_next.wtake = 1'h0;
    s_next.rvalid = 1'h0;
    s_next.tvalid = 1'h0;
    s_next.done = 1'h0;
    s_next.abort = 1'h0;
    s_next.cmd_ready = 1'h0;
    s_next.frame_q = bus.frame_n;
    xfer = !s_reg.irdy_n && !bus.trdy_n;
    last = xfer && s_reg.frame_n;
    s_next.gnt_n = !(!bus.req_n && s_reg.mst == MS_IDLE);
    case (s_reg.mst)
      MS_IDLE: begin
        // own turn only with bus idle
        if (cmd_valid_i && bus.req_n && s_reg.gnt_n && bus.frame_n && bus.irdy_n &&
            s_reg.tst == TS_IDLE) begin
          s_next.cmd_ready = 1'h1;
          s_next.gnt_n = 1'h1;
          s_next.frame_n = 1'h0;
          s_next.irdy_n = 1'h1;
          s_next.mctl_oe_n = 1'h0;
          s_next.ad = addr_i;
          s_next.cbe = cmd_i;
          s_next.ad_oe_n = 1'h0;
          s_next.cbe_oe_n = 1'h0;
          s_next.par_oe_n = 1'h0;
          s_next.idsel = cfg_sel_i;
          s_next.wr = cmd_i[0];
          s_next.cnt = (len_i == '0) ? LEN_ONE : len_i;
          s_next.mst = MS_ADDR;
        end
      end
      MS_ADDR: begin
        s_next.idsel = 1'h0;
        s_next.cbe = BE_ALL_N;
        s_next.tmo = '0;
        s_next.mst = MS_DATA;
        if (s_reg.wr) begin
          s_next.ad = wdata_i;
          s_next.irdy_n = !wvalid_i;
          s_next.frame_n = wvalid_i && (s_reg.cnt == LEN_ONE);
        end else begin
          s_next.ad_oe_n = 1'h1;
          s_next.par_oe_n = 1'h1;
          s_next.irdy_n = 1'h0;
          s_next.frame_n = s_reg.cnt == LEN_ONE;
        end
      end
      MS_DATA: begin
        if (bus.devsel_n && s_reg.tmo != MABORT_CLK) begin
          s_next.tmo = s_reg.tmo + 4'h1;
        end
        if (xfer) begin
          s_next.rdata = bus.ad;
          s_next.rvalid = !s_reg.wr;
          s_next.wtake = s_reg.wr;
          s_next.cnt = s_reg.cnt - LEN_ONE;
        end
        // last transfer, stop or no claim ends it
        if (last || !bus.stop_n || (s_reg.tmo == MABORT_CLK)) begin
          s_next.done = last;
          s_next.abort = !last;
          s_next.frame_n = 1'h1;
          s_next.irdy_n = 1'h1;
          s_next.ad_oe_n = 1'h1;
          s_next.cbe_oe_n = 1'h1;
          s_next.par_oe_n = 1'h1;
          s_next.mst = MS_TURN;
        end else if (xfer) begin
          s_next.irdy_n = s_reg.wr;
          s_next.frame_n = !s_reg.wr && (s_reg.cnt == LEN_TWO);
        end else if (s_reg.wr && s_reg.irdy_n && wvalid_i && !s_reg.wtake) begin
          s_next.ad = wdata_i;
          s_next.irdy_n = 1'h0;
          s_next.frame_n = s_reg.cnt == LEN_ONE;
        end
      end
      MS_TURN: begin
        s_next.mctl_oe_n = 1'h1;
        s_next.mst = MS_IDLE;
      end
      default: begin
        s_next.mst = MS_IDLE;
      end
    endcase

    case (s_reg.tst)
      TS_IDLE: begin
        if (!bus.frame_n && s_reg.frame_q && s_reg.mctl_oe_n && bus.cbe == CMD_MEM_WR) begin
          s_next.devsel_n = 1'h0;
          s_next.trdy_n = 1'h0;
          s_next.stop_n = 1'h1;
          s_next.tctl_oe_n = 1'h0;
          s_next.tst = TS_DATA;
        end
      end
      TS_DATA: begin
        if (!bus.irdy_n && !s_reg.trdy_n) begin
          s_next.tdata = bus.ad;
          s_next.tbe_n = bus.cbe;
          s_next.tvalid = 1'h1;
        end
        if (bus.frame_n) begin
          s_next.trdy_n = 1'h1;
          s_next.devsel_n = 1'h1;
          s_next.tst = TS_TURN;
        end
      end
      TS_TURN: begin
        s_next.tctl_oe_n = 1'h1;
        s_next.tst = TS_IDLE;
      end
      default: begin
        s_next.tst = TS_IDLE;
      end
    endcase
    s_next.par = pcis_par(s_next.ad, s_next.cbe);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_reg <= H_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cmd_ready_o = s_reg.cmd_ready;
  assign wtake_o = s_reg.wtake;
  assign rdata_o = s_reg.rdata;
  assign rvalid_o = s_reg.rvalid;
  assign done_o = s_reg.done;
  assign abort_o = s_reg.abort;
  assign tgt_data_o = s_reg.tdata;
  assign tgt_be_n_o = s_reg.tbe_n;
  assign tgt_valid_o = s_reg.tvalid;
  assign bus.h_ad = s_reg.ad;
  assign bus.h_ad_oe_n = s_reg.ad_oe_n;
  assign bus.h_cbe = s_reg.cbe;
  assign bus.h_cbe_oe_n = s_reg.cbe_oe_n;
  assign bus.h_par = s_reg.par;
  assign bus.h_par_oe_n = s_reg.par_oe_n;
  assign bus.h_frame_n = s_reg.frame_n;
  assign bus.h_irdy_n = s_reg.irdy_n;
  assign bus.h_mctl_oe_n = s_reg.mctl_oe_n;
  assign bus.h_trdy_n = s_reg.trdy_n;
  assign bus.h_stop_n = s_reg.stop_n;
  assign bus.h_devsel_n = s_reg.devsel_n;
  assign bus.h_tctl_oe_n = s_reg.tctl_oe_n;
  assign bus.h_idsel = s_reg.idsel;
  assign bus.h_gnt_n = s_reg.gnt_n;
endmodule
`default_nettype wire

// *** tb/pcis_chk.sv ***
// bus-level assertions across the device end and the host end
`timescale 1ns/1ps
`default_nettype none
module pcis_chk import pcis_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic devsel_n,
  input wire logic idsel,
  input wire logic req_n,
  input wire logic gnt_n,
  input wire logic d_ad_oe_n,
  input wire logic h_ad_oe_n,
  input wire logic d_mctl_oe_n,
  input wire logic h_mctl_oe_n
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ****************************************
  // protocol relations
  // ****************************************
  chk_par_even: assert property ((!irdy_n && !trdy_n) || $fell(frame_n) |-> ^{ad, cbe, par} == 1'b0)
    else $error("odd parity");
  chk_one_master: assert property (d_mctl_oe_n || h_mctl_oe_n)
    else $error("two masters drive");
  chk_dev_start: assert property (!d_mctl_oe_n && $fell(frame_n) |-> !$past(gnt_n) && $past(irdy_n))
    else $error("start without grant");
  chk_frame_last: assert property ($rose(frame_n) |-> !irdy_n || !$past(stop_n) || $past(devsel_n))
    else $error("frame ended early");
  chk_claim_cfg: assert property ($fell(frame_n) && idsel && cbe[3:1] == 3'h5 |=> !devsel_n)
    else $error("config not claimed");
  chk_stop_end: assert property (!stop_n && !trdy_n && !irdy_n |=> frame_n && irdy_n)
    else $error("stop ignored");
  chk_req_grant: assert property ($fell(req_n) |-> ##[1:200] !gnt_n)
    else $error("no grant");
  chk_grant_req: assert property ($fell(gnt_n) |-> !req_n)
    else $error("grant without request");
  chk_xfer_claim: assert property (!irdy_n && !trdy_n |-> !devsel_n)
    else $error("transfer unclaimed");
  chk_irdy_framed: assert property ($fell(irdy_n) |-> !$past(frame_n))
    else $error("ready outside frame");
  chk_rst_float: assert property (disable iff (1'b0) sys_rst_i && $past(sys_rst_i) |->
    d_ad_oe_n && h_ad_oe_n && d_mctl_oe_n && h_mctl_oe_n && req_n)
    else $error("driving in reset");
  cover property ($fell(frame_n) && cbe == CMD_CFG_WR);
  cover property (!stop_n && !trdy_n);
  cover property (!irdy_n && trdy_n && !devsel_n);
endmodule
`default_nettype wire

// *** tb/pci_bus_signalling_interface_test.sv ***
// self-checking bench joining device end and host end
`timescale 1ns/1ps
`default_nettype none
module pci_bus_signalling_interface_test import pcis_pkg::*; ;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cmd_valid_i, cfg_sel_i, wvalid_i, wr_ready_i, mst_start_i, drain;
  logic cmd_ready_o, wtake_o, rvalid_o, done_o, abort_o, tgt_valid_o;
  logic wr_valid_o, mst_busy_o, mst_done_o, mst_abort_o;
  logic [3:0] cmd_i, tgt_be_n_o, wr_be_n_o;
  logic [7:0] len_i;
  logic [31:0] addr_i, wdata_i, mst_addr_i, mst_data_i, rdata_o, tgt_data_o, wr_data_o, cfg_o, exp_rd, v;
  logic [31:0] wd[8];
  logic [31:0] fq[$];
  int seed = 32;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int wi;

  pcis_if bus ();
  pcis_host pcis_host_inst (.clk_i, .sys_rst_i, .bus(bus), .cmd_valid_i, .cmd_ready_o, .cmd_i, .addr_i,
    .len_i, .cfg_sel_i, .wdata_i, .wvalid_i, .wtake_o, .rdata_o, .rvalid_o, .done_o, .abort_o,
    .tgt_data_o, .tgt_be_n_o, .tgt_valid_o);
  pcis_dev #(.MEM_BASE(MEM_BASE_DEF), .DEPTH(FIFO_DEPTH)) pcis_dev_inst (.clk_i, .sys_rst_i, .bus(bus),
    .wr_data_o, .wr_be_n_o, .wr_valid_o, .wr_ready_i, .mst_start_i, .mst_addr_i, .mst_data_i,
    .mst_busy_o, .mst_done_o, .mst_abort_o, .cfg_o);
  pcis_chk pcis_chk_inst (.clk_i, .sys_rst_i, .ad(bus.ad), .cbe(bus.cbe), .par(bus.par),
    .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .trdy_n(bus.trdy_n), .stop_n(bus.stop_n),
    .devsel_n(bus.devsel_n), .idsel(bus.idsel), .req_n(bus.req_n), .gnt_n(bus.gnt_n),
    .d_ad_oe_n(bus.d_ad_oe_n), .h_ad_oe_n(bus.h_ad_oe_n), .d_mctl_oe_n(bus.d_mctl_oe_n),
    .h_mctl_oe_n(bus.h_mctl_oe_n));

  initial forever #20 clk_i = ~clk_i;

  function automatic logic in_win(input logic [31:0] a);
    return a[31:MEM_WIN_BITS] == MEM_BASE_DEF[31:MEM_WIN_BITS];
  endfunction

  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // bus drivers and monitors
  // ****************************************
  task automatic host_op(input logic [3:0] c, input logic [31:0] a, input logic [7:0] n, input logic s,
    input logic ab);
    int k;
    @(negedge clk_i);
    {cmd_i, addr_i, len_i, cfg_sel_i} = {c, a, n, s};
    wi = 0;
    wdata_i = wd[0];
    {wvalid_i, cmd_valid_i} = 2'h3;
    k = 0;
    while (cmd_ready_o !== 1'b1 && k < 50) begin
      @(negedge clk_i);
      k++;
    end
    cmd_valid_i = 1'b0;
    while (done_o !== 1'b1 && abort_o !== 1'b1 && k < 400) begin
      @(negedge clk_i);
      k++;
      if (wtake_o === 1'b1) begin
        wi++;
        wdata_i = wd[wi];
      end
      if (rvalid_o === 1'b1) chk(rdata_o, exp_rd);
    end
    chk({abort_o, k < 400}, {ab, 1'b1});
    wvalid_i = 1'b0;
  endtask

  task automatic dev_wr(input logic [31:0] a, input logic [31:0] d);
    int k;
    @(negedge clk_i);
    {mst_addr_i, mst_data_i, mst_start_i} = {a, d, 1'b1};
    @(negedge clk_i);
    mst_start_i = 1'b0;
    k = 0;
    while (mst_done_o !== 1'b1 && mst_abort_o !== 1'b1 && k < 400) begin
      @(negedge clk_i);
      k++;
      if (tgt_valid_o === 1'b1) chk({tgt_be_n_o, tgt_data_o}, {BE_ALL_N, d});
    end
    chk({mst_abort_o, mst_busy_o, k < 400}, 3'h3);
    @(negedge clk_i);
    chk(mst_busy_o, 1'b0);
  endtask

  always @(negedge clk_i) wr_ready_i <= drain && 1'($random(seed));

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) chk({wr_be_n_o, wr_data_o}, {BE_ALL_N, fq.pop_front()});
    if (cyc == 30000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    {cmd_valid_i, cfg_sel_i, wvalid_i, mst_start_i, drain, wr_ready_i} = '0;
    {cmd_i, len_i, addr_i, wdata_i, mst_addr_i, mst_data_i, exp_rd} = '0;
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk({wr_valid_o, cfg_o}, 0);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      exp_rd = v;
      wd[0] = v;
      fork
        host_op(CMD_CFG_WR, $random(seed), LEN_ONE, 1'b1, 1'b0);
        dev_wr($random(seed), $random(seed));
      join
      chk(cfg_o, v);
      host_op(CMD_CFG_RD, $random(seed), LEN_ONE, 1'b1, 1'b0);
      host_op(CMD_MEM_RD, MEM_BASE_DEF + 32'(i * 4), i[0] ? LEN_TWO : LEN_ONE, 1'b0, i[0]);
      wd[0] = ~v;
      host_op(CMD_CFG_WR, v, LEN_ONE, 1'b0, 1'b1);
      chk(cfg_o, v);
      $display("test round %0d done", i);
    end
    for (int i = 0; i < 6; i++) begin
      wd[i] = $random(seed);
      fq.push_back(wd[i]);
    end
    fork
      host_op(CMD_MEM_WR, MEM_BASE_DEF + 32'h10, 8'h06, 1'b0, !in_win(MEM_BASE_DEF + 32'h10));
      begin
        repeat (25) @(negedge clk_i);
        chk(wi, 4);
        drain = 1'b1;
      end
    join
    repeat (30) @(negedge clk_i);
    chk({fq.size(), wr_valid_o}, 0);
    v = {~MEM_BASE_DEF[31:12], 12'h040};
    host_op(CMD_MEM_WR, v, 8'h03, 1'b0, !in_win(v));
    $display("test burst done");
    sys_rst_i = 1'b1;
    @(negedge clk_i);
    chk({wr_valid_o, cfg_o}, 0);
    sys_rst_i = 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
